// ### hw/ssld_pkg.sv
/*
  Shared constants and carrier types for the serial shift latch driver.
  Assumes a single 100 MHz system clock; pins other than master_clear_n are sampled synchronously.
*/
// Summary of operation
// - Eight shift stages are fed from the serial input and copied into a separate storage register.
// - Each rising shift clock edge moves the stages up one place and takes in the serial input.
// - Each rising latch clock edge copies all eight stages into storage, which otherwise holds.
// - A low master clear empties both the stages and the storage at once, without a clock.
// - The cascade output changes only on a falling shift clock edge or a low master clear.
// - With both clocks tied together, storage takes the stages as they were before the edge.
// - With the gate low, each stored one turns its drain output on so it sinks current.
// - With the gate high, all eight drain outputs are off whatever is stored.
// - The output gate never changes the stages or the storage.
// - There are eight drain outputs, one per stored bit, that only sink and never drive high.
package ssld_pkg;
  localparam int unsigned SSLD_WIDTH = 8;
  localparam int unsigned SSLD_FIRST = 0;
  localparam int unsigned SSLD_LAST  = SSLD_WIDTH - 1;
  localparam logic [SSLD_WIDTH-1:0] SSLD_CLEAR = 8'h00;
  localparam logic                  SSLD_LOW   = 1'h0;

  typedef logic [SSLD_WIDTH-1:0] ssld_byte_t;

  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic latch_clock;
    logic output_gate_n;
  } ssld_ctrl_s;

  typedef struct packed {
    ssld_byte_t drain_out;
    ssld_byte_t drain_out_oe;
  } ssld_drain_s;

  function automatic logic ssld_rise(input logic prev, input logic now);
    return !prev && now;
  endfunction

  function automatic logic ssld_fall(input logic prev, input logic now);
    return prev && !now;
  endfunction
endpackage

// ### hw/ssld_top.sv
/*
  Serial shift latch driver: eight shift stages, a storage latch and
  eight open-drain outputs with a cascade output.
  Assumes shift_clock and latch_clock are slow pins synchronous to clock.
*/
`timescale 1ns/1ps
module ssld_top
  import ssld_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               master_clear_n,
  input  wire ssld_pkg::ssld_ctrl_s ctrl,
  output logic                    cascade_serial_out,
  output ssld_pkg::ssld_drain_s   drain
);
  import ssld_pkg::*;

  ssld_byte_t stage_reg;
  ssld_byte_t store_reg;
  logic       shift_prev_reg;
  logic       latch_prev_reg;
  logic       shift_rise;
  logic       shift_fall;
  logic       latch_rise;

  assign shift_rise = ssld_rise(shift_prev_reg, ctrl.shift_clock);
  assign shift_fall = ssld_fall(shift_prev_reg, ctrl.shift_clock);
  assign latch_rise = ssld_rise(latch_prev_reg, ctrl.latch_clock);

  // Edge history of the pin clocks
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shift_prev_reg <= SSLD_LOW;
      latch_prev_reg <= SSLD_LOW;
    end else begin
      shift_prev_reg <= ctrl.shift_clock;
      latch_prev_reg <= ctrl.latch_clock;
    end
  end

  // Shift stages
  always_ff @(posedge clock or negedge nrst or negedge master_clear_n) begin
    if (!nrst) begin
      stage_reg <= SSLD_CLEAR;
    end else if (!master_clear_n) begin
      stage_reg <= SSLD_CLEAR;
    end else if (shift_rise) begin
      stage_reg <= {stage_reg[SSLD_LAST-1:SSLD_FIRST], ctrl.serial_in};
    end
  end

  // Storage latch, old stage values when both edges coincide
  always_ff @(posedge clock or negedge nrst or negedge master_clear_n) begin
    if (!nrst) begin
      store_reg <= SSLD_CLEAR;
    end else if (!master_clear_n) begin
      store_reg <= SSLD_CLEAR;
    end else if (latch_rise) begin
      store_reg <= stage_reg;
    end
  end

  // Cascade output on falling shift edge
  always_ff @(posedge clock or negedge nrst or negedge master_clear_n) begin
    if (!nrst) begin
      cascade_serial_out <= SSLD_LOW;
    end else if (!master_clear_n) begin
      cascade_serial_out <= SSLD_LOW;
    end else if (shift_fall) begin
      cascade_serial_out <= stage_reg[SSLD_LAST];
    end
  end

  // Open-drain outputs, gate touches only the drivers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drain <= '0;
    end else begin
      drain.drain_out    <= SSLD_CLEAR;
      drain.drain_out_oe <= ctrl.output_gate_n ? SSLD_CLEAR : store_reg;
    end
  end

  // Shift stage checks
  AST_SHIFT: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    shift_rise |=> stage_reg == {$past(stage_reg[SSLD_LAST-1:SSLD_FIRST]), $past(ctrl.serial_in)})
    else $error("shift stage did not advance");

  AST_HOLD: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    !shift_rise |=> $stable(stage_reg))
    else $error("shift stage moved without edge");

  AST_STAGE_IN: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    shift_rise |=> stage_reg[SSLD_FIRST] == $past(ctrl.serial_in))
    else $error("first stage missed serial input");

  AST_LAST_MOVE: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    shift_rise |=> stage_reg[SSLD_LAST] == $past(stage_reg[SSLD_LAST-1]))
    else $error("last stage did not take its neighbour");

  AST_FALL_NO_SHIFT: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    shift_fall |=> $stable(stage_reg))
    else $error("stages moved on falling shift edge");

  AST_LATCH_NO_SHIFT: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    (latch_rise && !shift_rise) |=> $stable(stage_reg))
    else $error("latch edge moved the stages");

  // Storage checks
  AST_LATCH: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    latch_rise |=> store_reg == $past(stage_reg))
    else $error("storage missed latch edge");

  AST_TIED: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    (latch_rise && shift_rise) |=>
      store_reg == $past(stage_reg) &&
      stage_reg == {$past(stage_reg[SSLD_LAST-1:SSLD_FIRST]), $past(ctrl.serial_in)})
    else $error("storage not one pulse behind");

  AST_STORE_HOLD: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    !latch_rise |=> $stable(store_reg))
    else $error("storage changed without latch edge");

  AST_GATE_KEEP: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    ($changed(ctrl.output_gate_n) && !shift_rise && !latch_rise) |=>
      $stable(stage_reg) && $stable(store_reg))
    else $error("gate change disturbed the registers");

  // Clear checks
  AST_CLEAR: assert property (
    @(posedge clock) disable iff (!nrst)
    !master_clear_n |-> stage_reg == SSLD_CLEAR && store_reg == SSLD_CLEAR)
    else $error("clear did not empty registers");

  AST_CLEAR_CASCADE: assert property (
    @(posedge clock) disable iff (!nrst)
    !master_clear_n |-> cascade_serial_out == SSLD_LOW)
    else $error("clear left cascade output set");

  AST_CLEAR_OE: assert property (
    @(posedge clock) disable iff (!nrst)
    !master_clear_n |=> drain.drain_out_oe == SSLD_CLEAR)
    else $error("clear left an output on");

  // Cascade checks
  AST_CASCADE: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    !shift_fall |=> $stable(cascade_serial_out))
    else $error("cascade moved off falling edge");

  AST_CASCADE_VAL: assert property (
    @(posedge clock) disable iff (!nrst || !master_clear_n)
    shift_fall |=> cascade_serial_out == $past(stage_reg[SSLD_LAST]))
    else $error("cascade does not show last stage");

  // Output checks
  AST_GATE_OFF: assert property (
    @(posedge clock) disable iff (!nrst)
    ctrl.output_gate_n |=> drain.drain_out_oe == SSLD_CLEAR)
    else $error("outputs on while gated");

  AST_GATE_ON: assert property (
    @(posedge clock) disable iff (!nrst)
    !ctrl.output_gate_n |=> drain.drain_out_oe == $past(store_reg))
    else $error("output does not follow storage");

  AST_SINK: assert property (
    @(posedge clock) disable iff (!nrst)
    drain.drain_out == SSLD_CLEAR)
    else $error("drain output drives high");

  AST_SINK_ONLY: assert property (
    @(posedge clock) disable iff (!nrst)
    (drain.drain_out & drain.drain_out_oe) == SSLD_CLEAR)
    else $error("an enabled output drives high");

  // Per-output checks
  for (genvar b = 0; b < SSLD_WIDTH; b++) begin : g_bit_chk
    AST_BIT_ON: assert property (
      @(posedge clock) disable iff (!nrst)
      (!ctrl.output_gate_n && store_reg[b]) |=> drain.drain_out_oe[b])
      else $error("stored one left its output off");

    AST_BIT_OFF: assert property (
      @(posedge clock) disable iff (!nrst)
      (ctrl.output_gate_n || !store_reg[b]) |=> !drain.drain_out_oe[b])
      else $error("output on without a stored one");
  end

endmodule // ssld_top

// ### sim/ssld_host.sv
/* Host model that shifts bytes into the driver and latches them.
   Assumes the driver samples its pin clocks on clock. */
`timescale 1ns/1ps
module ssld_host (
  input  wire logic           clock,
  output ssld_pkg::ssld_ctrl_s ctrl
);
  import ssld_pkg::*;
  initial ctrl = 4'h1;
  task automatic step();
    repeat (2) @(posedge clock);
  endtask
  task automatic gate(input logic v);
    ctrl.output_gate_n <= v;
    step();
  endtask
  // Output seven bit first, then one latch pulse unless tied, which pulses latch with every shift
  task automatic send(input ssld_byte_t b, input logic tied);
    for (int i = 7; i >= 0; i--) begin
      ctrl.serial_in <= b[i];
      step();
      ctrl.shift_clock <= 1'b1;
      ctrl.latch_clock <= tied;
      step();
      ctrl.shift_clock <= 1'b0;
      ctrl.latch_clock <= 1'b0;
      ctrl.serial_in <= ~b[i];
      step();
    end
    if (!tied) begin
      ctrl.latch_clock <= 1'b1;
      step();
      ctrl.latch_clock <= 1'b0;
      step();
    end
  endtask
endmodule // ssld_host

// ### sim/ssld_top_tb.sv
/* Self-checking bench for the shift latch driver.
   Assumes the host model drives all pin clocks. */
`timescale 1ns/1ps
module ssld_top_tb;
  import ssld_pkg::*;
  logic        clock          = 1'b0;
  logic        nrst           = 1'b0;
  logic        master_clear_n = 1'b1;
  ssld_ctrl_s  ctrl;
  logic        cascade_serial_out;
  ssld_drain_s drain;
  int          bad_count      = 0;
  int          tests_run      = 0;
  always #5 clock = ~clock;
  ssld_host host (.clock(clock), .ctrl(ctrl));
  ssld_top dut (.clock(clock), .nrst(nrst), .master_clear_n(master_clear_n), .ctrl(ctrl),
    .cascade_serial_out(cascade_serial_out), .drain(drain));
  task automatic chk(input string n, input ssld_byte_t e, input ssld_byte_t s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic load_and_show();
    host.send(8'hA5, 1'b0);
    host.step();
    chk("held gated", 8'h00, drain.drain_out_oe);
    host.gate(1'b0);
    host.step();
    chk("oe", 8'hA5, drain.drain_out_oe);
    chk("cascade", 8'h01, {7'h00, cascade_serial_out});
    chk("level", 8'h00, drain.drain_out);
  endtask
  task automatic gate_off_on();
    host.gate(1'b1);
    host.step();
    chk("gated", 8'h00, drain.drain_out_oe);
    host.gate(1'b0);
    host.step();
    chk("ungated", 8'hA5, drain.drain_out_oe);
  endtask
  task automatic tied_clocks();
    host.send(8'h3C, 1'b1);
    host.step();
    chk("tied", 8'h9E, drain.drain_out_oe);
    chk("cascade tied", 8'h00, {7'h00, cascade_serial_out});
  endtask
  task automatic clear_all();
    master_clear_n <= 1'b0;
    host.step();
    chk("cleared", 8'h00, drain.drain_out_oe);
    chk("cascade clr", 8'h00, {7'h00, cascade_serial_out});
    master_clear_n <= 1'b1;
    host.step();
  endtask
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    host.step();
    load_and_show();
    gate_off_on();
    tied_clocks();
    clear_all();
    tally_and_finish();
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule // ssld_top_tb
